// ---- src/otcr_map.svh ----
/*
  register indices, reset values, field positions and timing
  figures of the overtemperature timer and configuration block.
  assumes byte address = 4 * index on a 32-bit wishbone bus.
*/
`ifndef OTCR_MAP_SVH
`define OTCR_MAP_SVH

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define OTCR_IDX_TMR   8'h79
`define OTCR_IDX_LIM   8'h7a
`define OTCR_IDX_TACH  8'h7b
`define OTCR_IDX_CFG   8'h7c
`define OTCR_IDX_LOCK  8'h80
`define OTCR_IDX_IST   8'h81
`define OTCR_IDX_IEN   8'h82
`define OTCR_IDX_ICLR  8'h83
`define OTCR_IDX_AUX   8'h84

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define OTCR_RST_TMR   8'h00
`define OTCR_RST_LIM   8'h00
`define OTCR_RST_TACH  8'h55
`define OTCR_RST_CFG   8'h01
`define OTCR_SYNC_IDLE 2'h1

// ---------------------------------------------------------------
// fields and codes
// ---------------------------------------------------------------
`define OTCR_IRQ_ASSERT 0
`define OTCR_IRQ_LIMIT  1
`define OTCR_AUX_OUT    0
`define OTCR_AUX_IN     1
`define OTCR_LOCK_BIT   0
`define OTCR_LIM_OFF64  8'h00
`define OTCR_LIM_TWOS   8'h80
`define OTCR_CNT_MAX    8'hff

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OTCR_STEP_NS    22760000
`define OTCR_CLK_NS     50
`define OTCR_MIN_NS     45520000
`define OTCR_MIN_STEPS  (`OTCR_MIN_NS / `OTCR_STEP_NS)

`endif

// ---- src/otcr_pkg.sv ----
/*
  types shared by the overtemperature timer and configuration block.
  assumes otcr_map.svh for all numeric values.
*/
package otcr_pkg;

  // bit 7 down to bit 0 of the configuration register
  typedef struct packed {
    logic r2_en;
    logic local_en;
    logic r1_en;
    logic voltage_id_pin_select;
    logic aux_pol;
    logic aux_dir;
    logic offset_1c;
    logic twos;
  } otcr_cfg_t;

  typedef logic [2:0] otcr_pulses_t;

endpackage

// ---- src/otcr_sync.sv ----
/*
  two flip-flop level synchroniser, one per bit.
  assumes inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module otcr_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  if (W < 1) begin : g_chk
    $error("otcr_sync: W must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- src/otcr_timer.sv ----
/*
  assertion duration counter: prescaler of STEP_CYCLES clocks per
  step and a saturating 8-bit step count, cleared by clear_i.
  assumes active_i is already synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
`include "otcr_map.svh"

module otcr_timer #(
  parameter int STEP_CYCLES = 455200
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       active_i,
  input  wire logic       clear_i,
  output var  logic [7:0] count_o
);

  localparam int PW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [PW-1:0] LAST = PW'(STEP_CYCLES - 1);

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [7:0]    next_count;

  if (STEP_CYCLES < 1) begin : g_chk
    $error("otcr_timer: STEP_CYCLES must be at least 1");
  end

  // ---------------------------------------------------------------
  // step prescaler and count
  // ---------------------------------------------------------------
  always_comb begin
    next_pre   = pre;
    next_count = count_o;
    if (active_i) begin
      if (pre == LAST) begin
        next_pre = '0;
        // hold at the top, a long event must not read short
        if (count_o != `OTCR_CNT_MAX) begin // R16
          next_count = count_o + 8'h01;
        end
      end else begin
        next_pre = pre + PW'(1);
      end
    end
    if (clear_i) begin
      next_count = `OTCR_RST_TMR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre     <= '0;
      count_o <= `OTCR_RST_TMR;
    end else begin
      pre     <= next_pre;
      count_o <= next_count;
    end
  end

endmodule

`default_nettype wire

// ---- src/otcr_regs.sv ----
/*
  overtemperature timer, duration limit, tach pulse select and pin
  configuration registers behind a classic wishbone slave.
  assumes the pin is active low open drain, channel compare and
  limit values come from the temperature logic on clk_i.
*/
// Added by the designer: the Wishbone register port.
// Contract
// (R01) lock bit set makes the configuration register ignore writes
// (R02) timer bits 7:1 read zero until assertion exceeds two steps
// (R03) bit 0 set on pin assertion, cleared when timer is read
// (R04) past two steps bit 0 is lsb of 8-bit step count
// (R05) count above duration limit raises the limit flag
// (R06) limit of zero raises the flag at assertion
// (R07) four 2-bit fields choose 1 to 4 tach pulses, reset 0x55
// (R08) format bit picks twos complement or offset-64 everywhere
// (R09) offset range bit picks half or whole degree offset steps
// (R10) aux pin direction bit: 0 input, 1 output when enabled
// (R11) aux pin polarity bit: 0 active low, 1 active high
// (R12) pin function bit: 0 voltage id, 1 general purpose
// (R13) per channel enables let over-limit drive the pin
// (R14) limit at -64 or -128 disables that channel's drive
// (R15) reset loads 0x00, 0x00, 0x55 and 0x01
// (R16) step count saturates at its maximum
`timescale 1ns/1ns
`default_nettype none
`include "otcr_map.svh"

module otcr_regs #(
  parameter int STEP_CYCLES = `OTCR_STEP_NS / `OTCR_CLK_NS
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [9:0]          adr_i,
  input  wire logic [31:0]         dat_i,
  output var  logic [31:0]         dat_o,
  input  wire logic [3:0]          sel_i,
  input  wire logic                we_i,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  output var  logic                ack_o,
  input  wire logic                overtemp_signal_i,
  output var  logic                overtemp_signal_o,
  output var  logic                overtemp_signal_oe_o,
  input  wire logic [2:0]          chan_over_i,
  input  wire logic [2:0][7:0]     chan_limit_i,
  input  wire logic                aux_io_enable_i,
  input  wire logic                aux_io_pin_i,
  output var  logic                aux_io_pin_o,
  output var  logic                aux_io_pin_oe_o,
  output var  otcr_pkg::otcr_cfg_t cfg_o,
  output var  otcr_pkg::otcr_pulses_t [3:0] tach_pulses_o,
  output var  logic                duration_limit_flag_o,
  output var  logic                int_o
);

  localparam logic [7:0] TACH_RST = `OTCR_RST_TACH;
  localparam logic [7:0] MIN_STEPS = 8'(`OTCR_MIN_STEPS);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pins_s;
  logic       active;
  logic       active_d;
  logic       rise;
  logic       aux_in;

  // reset to the idle pin level, else release looks like an assertion
  otcr_sync #(
    .W       (2),
    .RST_VAL (`OTCR_SYNC_IDLE)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({aux_io_pin_i, overtemp_signal_i}),
    .q_o   (pins_s)
  );

  assign active = ~pins_s[0];
  assign aux_in = pins_s[1];
  assign rise   = active & ~active_d;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [7:0] idx;
  logic       req;
  logic       wr;
  logic       rd;
  logic       wr_cfg_req;
  logic       rd_tmr;

  assign idx        = adr_i[9:2];
  assign req        = cyc_i & stb_i & ~ack_o;
  assign wr         = req & we_i & sel_i[0];
  assign rd         = req & ~we_i;
  assign wr_cfg_req = wr & (idx == `OTCR_IDX_CFG);
  assign rd_tmr     = rd & (idx == `OTCR_IDX_TMR);

  // ---------------------------------------------------------------
  // duration timer
  // ---------------------------------------------------------------
  logic [7:0] cnt;
  logic [7:0] stat;

  otcr_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .active_i (active),
    .clear_i  (rd_tmr),
    .count_o  (cnt)
  );

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic       aflag;
  logic [7:0] lim;
  logic [7:0] tach;
  logic       lock;
  logic [1:0] ist;
  logic [1:0] ien;
  logic       aux_out;
  logic       hit;
  logic       lim_ev;
  logic [2:0] chan_dis;
  logic [2:0] chan_en;
  logic [1:0] ev;
  logic [1:0] clr;
  logic [7:0] rdata;

  logic                next_aflag;
  logic [7:0]          next_lim;
  logic [7:0]          next_tach;
  otcr_pkg::otcr_cfg_t next_cfg;
  logic                next_lock;
  logic [1:0]          next_ist;
  logic [1:0]          next_ien;
  logic                next_aux_out;
  logic                next_hit;

  // below two steps only the flag shows
  assign stat = (cnt >= MIN_STEPS) ? cnt // R04
              : {7'h00, aflag}; // R02

  // limit event once per assertion
  assign lim_ev = active & ~hit &
                  ((lim == `OTCR_LIM_OFF64) ? rise // R06
                                            : (cnt > lim)); // R05

  assign ev[`OTCR_IRQ_ASSERT] = rise;
  assign ev[`OTCR_IRQ_LIMIT]  = lim_ev;
  assign clr = (wr && idx == `OTCR_IDX_ICLR) ? dat_i[1:0] : 2'h0;

  always_comb begin
    next_aflag   = rise | (aflag & ~rd_tmr); // R03
    next_hit     = active & (hit | lim_ev);
    // set wins over a same-cycle clear
    next_ist     = (ist & ~clr) | ev;
    next_lim     = lim;
    next_tach    = tach;
    next_cfg     = cfg_o;
    next_lock    = lock;
    next_ien     = ien;
    next_aux_out = aux_out;
    if (wr) begin
      if (idx == `OTCR_IDX_LIM) begin
        next_lim = dat_i[7:0];
      end else if (idx == `OTCR_IDX_TACH) begin
        next_tach = dat_i[7:0];
      end else if (idx == `OTCR_IDX_CFG) begin
        // locked: write is acked but dropped
        if (!lock) begin // R01
          next_cfg = otcr_pkg::otcr_cfg_t'(dat_i[7:0]);
        end
      end else if (idx == `OTCR_IDX_LOCK) begin
        // only reset releases the lock
        next_lock = lock | dat_i[`OTCR_LOCK_BIT];
      end else if (idx == `OTCR_IDX_IEN) begin
        next_ien = dat_i[1:0];
      end else if (idx == `OTCR_IDX_AUX) begin
        next_aux_out = dat_i[`OTCR_AUX_OUT];
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (idx == `OTCR_IDX_TMR) begin
      rdata = stat;
    end else if (idx == `OTCR_IDX_LIM) begin
      rdata = lim;
    end else if (idx == `OTCR_IDX_TACH) begin
      rdata = tach;
    end else if (idx == `OTCR_IDX_CFG) begin
      rdata = cfg_o;
    end else if (idx == `OTCR_IDX_LOCK) begin
      rdata = {7'h00, lock};
    end else if (idx == `OTCR_IDX_IST) begin
      rdata = {6'h00, ist};
    end else if (idx == `OTCR_IDX_IEN) begin
      rdata = {6'h00, ien};
    end else if (idx == `OTCR_IDX_AUX) begin
      rdata = {6'h00, aux_in, aux_out};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aflag    <= 1'b0;
      hit      <= 1'b0;
      active_d <= 1'b0;
      lim      <= `OTCR_RST_LIM; // R15
      tach     <= `OTCR_RST_TACH; // R15
      cfg_o    <= otcr_pkg::otcr_cfg_t'(`OTCR_RST_CFG); // R15
      lock     <= 1'b0;
      ist      <= 2'h0;
      ien      <= 2'h0;
      aux_out  <= 1'b0;
    end else begin
      aflag    <= next_aflag;
      hit      <= next_hit;
      active_d <= active;
      lim      <= next_lim;
      tach     <= next_tach;
      cfg_o    <= next_cfg; // R08 R09 R12
      lock     <= next_lock;
      ist      <= next_ist;
      ien      <= next_ien;
      aux_out  <= next_aux_out;
    end
  end

  // ---------------------------------------------------------------
  // bus answer, interrupt and pins
  // ---------------------------------------------------------------
  logic       next_ack;
  logic [31:0] next_dat;
  logic       next_int;
  logic       next_ot_oe;
  logic       next_aux_oe;
  logic       next_aux_pin;

  assign chan_en = {cfg_o.r2_en, cfg_o.local_en, cfg_o.r1_en};

  for (genvar c = 0; c < 3; c++) begin : g_chan
    // disable code depends on the live number format
    assign chan_dis[c] = cfg_o.twos // R14
                       ? (chan_limit_i[c] == `OTCR_LIM_TWOS)
                       : (chan_limit_i[c] == `OTCR_LIM_OFF64);
  end

  always_comb begin
    next_ack     = req;
    next_dat     = req ? {24'h000000, rdata} : dat_o;
    next_int     = |(next_ist & ien);
    next_ot_oe   = |(chan_en & chan_over_i & ~chan_dis); // R13
    next_aux_oe  = aux_io_enable_i & cfg_o.aux_dir; // R10
    next_aux_pin = cfg_o.aux_pol ? aux_out : ~aux_out; // R11
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o                 <= 1'b0;
      dat_o                 <= 32'h00000000;
      int_o                 <= 1'b0;
      duration_limit_flag_o <= 1'b0;
      overtemp_signal_o     <= 1'b0;
      overtemp_signal_oe_o  <= 1'b0;
      aux_io_pin_oe_o       <= 1'b0;
      aux_io_pin_o          <= 1'b1;
    end else begin
      ack_o                 <= next_ack;
      dat_o                 <= next_dat;
      int_o                 <= next_int;
      duration_limit_flag_o <= lim_ev; // R05
      overtemp_signal_o     <= 1'b0;
      overtemp_signal_oe_o  <= next_ot_oe;
      aux_io_pin_oe_o       <= next_aux_oe;
      aux_io_pin_o          <= next_aux_pin;
    end
  end

  // ---------------------------------------------------------------
  // tach pulse counts
  // ---------------------------------------------------------------
  for (genvar f = 0; f < 4; f++) begin : g_fan
    otcr_pkg::otcr_pulses_t next_pulses;
    always_comb begin
      next_pulses = {1'b0, tach[2*f +: 2]} + 3'h1; // R07
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tach_pulses_o[f] <= {1'b0, TACH_RST[2*f +: 2]} + 3'h1;
      end else begin
        tach_pulses_o[f] <= next_pulses;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  lock_hold_a: assert property ( // R01
    lock && wr_cfg_req |=> cfg_o == $past(cfg_o))
    else $error("config changed while locked");

  zero_upper_a: assert property ( // R02
    cnt < MIN_STEPS |-> stat[7:1] == 7'h00)
    else $error("timer upper bits not zero");

  flag_set_a: assert property ( // R03
    rise |=> aflag ##0 (stat[0] || cnt >= MIN_STEPS))
    else $error("assert flag not set");

  flag_clr_a: assert property ( // R03
    rd_tmr && !rise ##1 !rise |-> !aflag)
    else $error("assert flag not cleared by read");

  count_lsb_a: assert property ( // R04
    cnt >= MIN_STEPS |-> stat == cnt)
    else $error("timer does not show count");

  limit_over_a: assert property ( // R05
    active && !hit && lim != 8'h00 && cnt > lim
    |=> duration_limit_flag_o && ist[`OTCR_IRQ_LIMIT])
    else $error("limit exceed not flagged");

  limit_zero_a: assert property ( // R06
    lim == 8'h00 && rise |=> duration_limit_flag_o)
    else $error("zero limit not immediate");

  tach_sel_a: assert property ( // R07
    1'b1 |=> tach_pulses_o[3] == 3'($past(tach[7:6])) + 3'h1)
    else $error("tach pulse count wrong");

  aux_dir_a: assert property ( // R10
    1'b1 |=> aux_io_pin_oe_o == $past(aux_io_enable_i && cfg_o.aux_dir))
    else $error("aux pin direction wrong");

  ot_disable_a: assert property ( // R14
    (chan_dis | ~chan_en) == 3'h7 |=> !overtemp_signal_oe_o)
    else $error("disabled channel drives pin");

  sat_hold_a: assert property ( // R16
    cnt == `OTCR_CNT_MAX && !rd_tmr |=> cnt == `OTCR_CNT_MAX)
    else $error("duration count wrapped");

  reset_val_a: assert property ( // R15
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> lim == `OTCR_RST_LIM && tach == `OTCR_RST_TACH
              && cfg_o == `OTCR_RST_CFG && stat == `OTCR_RST_TMR)
    else $error("reset values wrong");

endmodule

`default_nettype wire

// ---- verif/otcr_host.sv ----
/*
  host side model: classic wishbone master for the register bank.
  assumes the bench calls xfer from one process on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module otcr_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic [9:0]  adr_o,
  output var  logic [31:0] dat_o,
  output var  logic [3:0]  sel_o,
  output var  logic        we_o,
  output var  logic        cyc_o,
  output var  logic        stb_o
);
  initial begin
    adr_o = 10'h000;
    dat_o = 32'h00000000;
    sel_o = 4'h0;
    we_o  = 1'b0;
    cyc_o = 1'b0;
    stb_o = 1'b0;
  end

  // one cycle; released data flips so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    dat_o <= {24'h000000, d};
    sel_o <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    ok = (ack_i === 1'b1);
    q = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    sel_o <= 4'h0;
    dat_o <= ~dat_o;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_otcr_regs.sv ----
/*
  self-checking bench for the overtemperature timer register bank.
  assumes STEP_CYCLES of 4 and a pulled-up, open-drain pin.
*/
`timescale 1ns/1ns
`default_nettype none
`include "otcr_map.svh"

module test_otcr_regs;
  logic                         clk_i   = 1'b0;
  logic                         rst_i   = 1'b1;
  logic                         pull    = 1'b0;
  logic [2:0]                   over    = 3'h0;
  logic [2:0][7:0]              lim     = 24'h404040;
  logic                         aux_en  = 1'b0;
  logic                         aux_ext = 1'b1;
  logic [9:0]                   adr;
  logic [31:0]                  wdat;
  logic [31:0]                  rdat;
  logic [3:0]                   sel;
  logic                         we;
  logic                         cyc;
  logic                         stb;
  logic                         ack;
  logic                         ot_o;
  logic                         ot_oe;
  logic                         aux_o;
  logic                         aux_oe;
  logic                         flag;
  logic                         irq;
  wire                          ot_pin;
  wire                          aux_pin;
  otcr_pkg::otcr_cfg_t          cfg;
  otcr_pkg::otcr_pulses_t [3:0] pulses;
  int                           n_mismatch = 0;
  int                           checked    = 0;
  int                           n_flag     = 0;
  int                           mdl [int];
  logic                         locked = 1'b0;
  logic [7:0]                   q;
  logic                         ok;

  always #25 clk_i = ~clk_i;
  // wired low by either party, pull-up otherwise
  assign ot_pin  = (ot_oe ? ot_o : 1'b1) & ~pull;
  assign aux_pin = aux_oe ? aux_o : aux_ext;
  always @(posedge clk_i) if (flag === 1'b1) n_flag <= n_flag + 1;

  otcr_host i_otcr_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel), .we_o(we), .cyc_o(cyc),
    .stb_o(stb));

  otcr_regs #(.STEP_CYCLES(4)) i_otcr_regs (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .overtemp_signal_i(ot_pin),
    .overtemp_signal_o(ot_o), .overtemp_signal_oe_o(ot_oe),
    .chan_over_i(over), .chan_limit_i(lim), .aux_io_enable_i(aux_en),
    .aux_io_pin_i(aux_pin), .aux_io_pin_o(aux_o),
    .aux_io_pin_oe_o(aux_oe), .cfg_o(cfg), .tach_pulses_o(pulses),
    .duration_limit_flag_o(flag), .int_o(irq));

  // ---------------------------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp1(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
    i_otcr_host.xfer(w, i, d, q, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, i, d);
    if (!(i == `OTCR_IDX_CFG && locked) && i != `OTCR_IDX_ICLR) mdl[i] = d;
    if (i == `OTCR_IDX_LOCK) locked = 1'b1;
  endtask

  task automatic expect_rd(input logic [7:0] i, input logic [7:0] e);
    acc(1'b0, i, 8'h00);
    cmp8(e, q);
  endtask

  task automatic chk_rd(input logic [7:0] i);
    expect_rd(i, mdl.exists(i) ? 8'(mdl[i]) : 8'h00);
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl.delete();
    mdl[`OTCR_IDX_TACH] = 8'h55;
    mdl[`OTCR_IDX_CFG] = 8'h01;
    locked = 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // pin held low for k cycles, then time for sync and count to settle
  task automatic hold(input int k);
    n_flag = 0;
    pull <= 1'b1;
    repeat (k) @(posedge clk_i);
    pull <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    int s;
    logic [7:0] v;
    logic t;
    int c;
    s = $urandom(32'h5b80);
    do_reset();
    chk_rd(`OTCR_IDX_TMR);
    chk_rd(`OTCR_IDX_LIM);
    chk_rd(`OTCR_IDX_CFG);
    cmp8(8'h01, cfg);
    for (int f = 0; f < 4; f++) cmp8(8'h02, {5'h0, pulses[f]});
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'he4 : 8'($urandom);
      wr(`OTCR_IDX_TACH, v);
      chk_rd(`OTCR_IDX_TACH);
      for (int f = 0; f < 4; f++) begin
        cmp8(v[2*f+:2] + 8'h01, {5'h0, pulses[f]});
      end
      v = 8'($urandom);
      wr(`OTCR_IDX_CFG, v);
      chk_rd(`OTCR_IDX_CFG);
      cmp8(v, cfg);
    end
    $display("test fields done");
    for (int k = 0; k < 16; k++) begin
      wr(`OTCR_IDX_CFG, {4'h0, k[2], k[1], 2'h1});
      wr(`OTCR_IDX_AUX, {7'h0, k[3]});
      aux_en <= k[0];
      aux_ext <= 1'($urandom);
      repeat (3) @(posedge clk_i);
      cmp1(k[0] & k[1], aux_oe);
      cmp1(k[2] ? k[3] : ~k[3], aux_o);
      t = (k[0] & k[1]) ? ~(k[2] ^ k[3]) : aux_ext;
      expect_rd(`OTCR_IDX_AUX, {6'h0, t, k[3]});
    end
    $display("test aux done");
    for (int k = 0; k < 6; k++) begin
      c = k % 3;
      t = (k > 2);
      wr(`OTCR_IDX_CFG, 8'(8'h20 << c) | {7'h0, t});
      over <= 3'(3'h1 << c);
      repeat (3) @(posedge clk_i);
      cmp1(1'b1, ot_oe);
      cmp1(1'b0, ot_o);
      lim[c] <= t ? 8'h80 : 8'h00;
      repeat (3) @(posedge clk_i);
      cmp1(1'b0, ot_oe);
      lim[c] <= 8'h40;
      wr(`OTCR_IDX_CFG, {7'h0, t});
      repeat (3) @(posedge clk_i);
      cmp1(1'b0, ot_oe);
      over <= 3'h0;
    end
    $display("test drive done");
    do_reset();
    wr(`OTCR_IDX_IEN, 8'h03);
    hold(4);
    cmp8(8'h01, 8'(n_flag));
    expect_rd(`OTCR_IDX_TMR, 8'h01);
    expect_rd(`OTCR_IDX_TMR, 8'h00);
    expect_rd(`OTCR_IDX_IST, 8'h03);
    cmp1(1'b1, irq);
    wr(`OTCR_IDX_ICLR, 8'h03);
    repeat (2) @(posedge clk_i);
    cmp1(1'b0, irq);
    expect_rd(`OTCR_IDX_IST, 8'h00);
    do_reset();
    hold(22);
    expect_rd(`OTCR_IDX_TMR, 8'h05);
    $display("test timer done");
    do_reset();
    wr(`OTCR_IDX_LIM, 8'h03);
    wr(`OTCR_IDX_IEN, 8'h02);
    hold(26);
    cmp8(8'h01, 8'(n_flag));
    expect_rd(`OTCR_IDX_TMR, 8'h06);
    expect_rd(`OTCR_IDX_IST, 8'h03);
    cmp1(1'b1, irq);
    do_reset();
    wr(`OTCR_IDX_LIM, 8'h06);
    hold(26);
    cmp8(8'h00, 8'(n_flag));
    expect_rd(`OTCR_IDX_IST, 8'h01);
    cmp1(1'b0, irq);
    do_reset();
    wr(`OTCR_IDX_LIM, 8'hff);
    hold(1040);
    expect_rd(`OTCR_IDX_TMR, 8'hff);
    cmp8(8'h00, 8'(n_flag));
    $display("test limit done");
    v = 8'($urandom);
    wr(`OTCR_IDX_CFG, v);
    wr(`OTCR_IDX_LOCK, 8'h01);
    wr(`OTCR_IDX_CFG, ~v);
    chk_rd(`OTCR_IDX_CFG);
    cmp8(v, cfg);
    expect_rd(`OTCR_IDX_LOCK, 8'h01);
    expect_rd(8'h90, 8'h00);
    expect_rd(`OTCR_IDX_ICLR, 8'h00);
    $display("test lock done");
    complete_run();
  end
endmodule
`default_nettype wire
